// ===== core/mmd_decoder.sv
/*
 * mmd_decoder: software configurable address decoder with four write-only
 * registers, memory selects, peripheral selects and flash bank lines.
 * Assumes the bus strobes are active high and synchronous to clk, and that
 * the board reports socket population as static levels.
 */
// Operation
// R1: four write-only registers written by xdata cycles
// R2: software writes zero into reserved bits
// R3: reset clears registers, giving default model
// R4: registers at 7C00-7C03 or FC00-FC03
// R5: i/o area FC00-FFFF, or 7C00-7FFF
// R6: four 256-byte blocks, three peripheral, one registers
// R7: peripheral selects on xdata read and write
// R8: i/o area accesses select no memory
// R9: ram halves follow swap bit
// R10: unpopulated socket range reaches no memory
// R11: program model: flash low, ram high
// R12: program model flash write-xdata, read-code only
// R13: flash A15 from register only in program model
// R14: runtime model drives latched flash bank bits
// R15: shared enable off ignores pattern and exclude
// R16: program model ignores shared enable, honours window
// R17: shared regions send code and xdata to ram
// R18: separate regions: code to flash, xdata ram
// R19: board keeps circuitry out of register block
// R20: software shadows every written register value
// R21: pattern compared against address bits 15..10
// R22: exclude bits drop pattern bits from compare
// R23: selects decoded combinationally within the bus cycle
module mmd_decoder (
   input wire logic clk,
   input wire logic reset,
   input wire mmd_pkg::mmd_bus_t bus,
   input wire logic primary_ram_socket_present,
   input wire logic secondary_ram_socket_present,
   output logic flash_select,
   output logic flash_read,
   output logic flash_write,
   output logic [3:0] flash_upper_addr,
   output logic primary_ram_socket_select,
   output logic secondary_ram_socket_select,
   output logic ram_read,
   output logic ram_write,
   output logic [1:0] ram_bank_addr,
   output logic peripheral_select_first,
   output logic peripheral_select_second,
   output logic peripheral_select_third
);

   mmd_pkg::mmd_ctrl_t ctrl_r;
   logic [7:0] ctrl_secondary_r;
   logic [7:0] pattern_match_bits_r;
   logic [7:0] pattern_exclude_bits_r;

   logic xdata_any;
   logic io_hit;
   logic [1:0] io_block;
   logic reg_hit;
   logic reg_write;
   logic [5:0] cmp_diff;
   logic separate_region;
   logic low_half;
   logic primary_half;
   logic prog_flash_xwr;
   logic prog_flash_code;
   logic run_flash_code;
   logic ram_xdata;
   logic ram_code;
   logic ram_any;

   // address decode of the i/o window; the window moves with the select bit
   assign xdata_any = bus.xdata_rd | bus.xdata_wr;
   assign io_hit = (bus.addr[14:10] == mmd_pkg::IO_AREA_TAG) &&
                   (bus.addr[15] == ~ctrl_r.io_window_high_low_select); // R5 R16
   assign io_block = bus.addr[9:8]; // R6
   // only the first four bytes answer; the rest of the block stays unused
   assign reg_hit = io_hit && (io_block == mmd_pkg::IO_BLK_REGS) &&
                    (bus.addr[7:2] == 6'h00); // R4
   assign reg_write = bus.xdata_wr && reg_hit; // R1

   // primary control register: all eight bits carry function
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_r <= mmd_pkg::mmd_ctrl_t'(mmd_pkg::REG_RESET); // R3
      end else if (reg_write && bus.addr[1:0] == mmd_pkg::OFS_CTRL_PRIMARY) begin
         ctrl_r <= mmd_pkg::mmd_ctrl_t'(bus.wdata); // R1
      end
   end

   // secondary control register: ram bank latch in the low two bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_secondary_r <= mmd_pkg::REG_RESET; // R3
      end else if (reg_write && bus.addr[1:0] == mmd_pkg::OFS_CTRL_SECONDARY) begin
         ctrl_secondary_r <= bus.wdata & mmd_pkg::SECONDARY_USED_MASK; // R1
      end
   end

   // pattern and exclude registers; reserved bits are masked to zero on write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pattern_match_bits_r <= mmd_pkg::REG_RESET; // R3
         pattern_exclude_bits_r <= mmd_pkg::REG_RESET; // R22
      end else if (reg_write) begin
         if (bus.addr[1:0] == mmd_pkg::OFS_PATTERN) begin
            pattern_match_bits_r <= bus.wdata & mmd_pkg::CMP_USED_MASK; // R1
         end
         if (bus.addr[1:0] == mmd_pkg::OFS_EXCLUDE) begin
            pattern_exclude_bits_r <= bus.wdata & mmd_pkg::CMP_USED_MASK; // R1
         end
      end
   end

   // region compare: a cleared exclude bit keeps that address line in play
   assign cmp_diff = (bus.addr[15:10] ^
                      pattern_match_bits_r[mmd_pkg::CMP_MSB:mmd_pkg::CMP_LSB]) &
                     ~pattern_exclude_bits_r[mmd_pkg::CMP_MSB:mmd_pkg::CMP_LSB]; // R21 R22
   // with sharing off every address is a separate code/data region
   assign separate_region = ~ctrl_r.shared_code_data_enable || (cmp_diff == 6'h00); // R15

   // ram half steering; program model always puts ram in the upper half
   assign low_half = ~bus.addr[15];
   assign primary_half = ctrl_r.flash_program_model_select ? ~low_half :
                         (bus.addr[15] == ctrl_r.ram_half_swap); // R9 R11

   // flash paths: program model writes by xdata and reads by code only
   assign prog_flash_xwr = ctrl_r.flash_program_model_select && low_half &&
                           bus.xdata_wr && ~io_hit; // R12 R8
   assign prog_flash_code = ctrl_r.flash_program_model_select && low_half &&
                            bus.code_rd; // R12
   // runtime code fetches go to flash only in separate regions
   assign run_flash_code = ~ctrl_r.flash_program_model_select && bus.code_rd &&
                           separate_region; // R18 R16

   // ram paths; code fetches reach ram in shared regions or the program upper half
   assign ram_xdata = xdata_any && ~io_hit &&
                      (~ctrl_r.flash_program_model_select || ~low_half); // R8 R11
   assign ram_code = bus.code_rd &&
                     (ctrl_r.flash_program_model_select ? ~low_half
                                                        : ~separate_region); // R17 R12
   assign ram_any = ram_xdata || ram_code;

   // selects are combinational so they are valid inside the same bus cycle;
   // a registered version would land one clock late for the memories
   always_comb begin
      flash_select = prog_flash_xwr || prog_flash_code || run_flash_code; // R23
      flash_read = prog_flash_code || run_flash_code; // R12
      flash_write = prog_flash_xwr; // R12
      primary_ram_socket_select = ram_any && primary_half &&
                                  primary_ram_socket_present; // R10 R9
      secondary_ram_socket_select = ram_any && ~primary_half &&
                                    ~ctrl_r.flash_program_model_select &&
                                    secondary_ram_socket_present; // R10 R9
      ram_read = ram_code || (ram_xdata && bus.xdata_rd);
      ram_write = ram_xdata && bus.xdata_wr;
   end

   // peripheral selects: one per peripheral block, on xdata read or write
   always_comb begin
      peripheral_select_first = xdata_any && io_hit &&
                                (io_block == mmd_pkg::IO_BLK_FIRST); // R7
      peripheral_select_second = xdata_any && io_hit &&
                                 (io_block == mmd_pkg::IO_BLK_SECOND); // R7
      peripheral_select_third = xdata_any && io_hit &&
                                (io_block == mmd_pkg::IO_BLK_THIRD); // R7
   end

   // flash upper lines straight from the latch; A15 follows the model
   always_comb begin
      flash_upper_addr[3:1] = {ctrl_r.flash_bank_bit_two, ctrl_r.flash_bank_bit_one,
                               ctrl_r.flash_bank_bit_zero}; // R14
      flash_upper_addr[0] = ctrl_r.flash_program_model_select ?
                            ctrl_r.flash_half_select_override : bus.addr[15]; // R13
   end

   // ram bank lines are plain latch outputs
   assign ram_bank_addr = ctrl_secondary_r[1:0];

   // assertions: one clock domain, so a default clocking serves them all
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // a primary control register write lands in that register next cycle
   property p_ctrl_write;
      (bus.xdata_wr && reg_hit && bus.addr[1:0] == mmd_pkg::OFS_CTRL_PRIMARY)
         |=> (ctrl_r == $past(bus.wdata));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) // R1
      else $error("primary control register did not take the written byte");

   // register block position follows the window bit
   property p_reg_window;
      (bus.xdata_wr && bus.addr[15:2] == mmd_pkg::REG_BASE_HIGH[15:2] &&
       !ctrl_r.io_window_high_low_select) |-> reg_write;
   endproperty
   a_reg_window: assert property (p_reg_window) // R4
      else $error("register write in high window not decoded");

   // nothing written outside the register block changes the primary control, pattern or exclude register
   property p_no_stray_write;
      !reg_write |=> $stable(ctrl_r) && $stable(pattern_match_bits_r) &&
                     $stable(pattern_exclude_bits_r);
   endproperty
   a_no_stray_write: assert property (p_no_stray_write) // R1
      else $error("configuration changed without a register write");

   // i/o accesses never select a memory
   property p_io_no_memory;
      (io_hit && xdata_any) |-> !primary_ram_socket_select &&
                                !secondary_ram_socket_select && !flash_write;
   endproperty
   a_io_no_memory: assert property (p_io_no_memory) // R8
      else $error("memory selected inside i/o area");

   // peripheral select matches its block and strobe
   property p_periph;
      peripheral_select_second |-> xdata_any &&
         bus.addr[15:8] == {~ctrl_r.io_window_high_low_select, 7'h7E};
   endproperty
   a_periph: assert property (p_periph) // R7
      else $error("second peripheral select outside its block");

   // default model: xdata reads in the half whose A15 equals the swap bit go to the primary socket
   property p_swap;
      (!ctrl_r.flash_program_model_select && bus.xdata_rd && !io_hit &&
       primary_ram_socket_present && bus.addr[15] == ctrl_r.ram_half_swap)
         |-> primary_ram_socket_select && !secondary_ram_socket_select;
   endproperty
   a_swap: assert property (p_swap) // R9
      else $error("ram half swap not followed");

   // unpopulated socket is never selected
   property p_unpopulated;
      !secondary_ram_socket_present |-> !secondary_ram_socket_select;
   endproperty
   a_unpopulated: assert property (p_unpopulated) // R10
      else $error("absent socket selected");

   // program model: xdata reads of low half never read flash
   property p_prog_flash;
      (ctrl_r.flash_program_model_select && bus.xdata_rd && !bus.code_rd)
         |-> !flash_read;
   endproperty
   a_prog_flash: assert property (p_prog_flash) // R12
      else $error("flash read by xdata in program model");

   // flash A15 source depends on the model
   property p_flash_a15;
      !ctrl_r.flash_program_model_select |-> flash_upper_addr[0] == bus.addr[15];
   endproperty
   a_flash_a15: assert property (p_flash_a15) // R13
      else $error("flash A15 not from controller in runtime model");

   // sharing off: every runtime code fetch goes to flash
   property p_sharing_off;
      (!ctrl_r.shared_code_data_enable && !ctrl_r.flash_program_model_select &&
       bus.code_rd) |-> flash_read && !ram_read;
   endproperty
   a_sharing_off: assert property (p_sharing_off) // R15
      else $error("code fetch left flash with sharing disabled");

   // shared region: code fetch reaches ram, not flash
   property p_shared;
      (ctrl_r.shared_code_data_enable && !ctrl_r.flash_program_model_select &&
       bus.code_rd && cmp_diff != 6'h00) |-> !flash_select && ram_read;
   endproperty
   a_shared: assert property (p_shared) // R17
      else $error("shared region code fetch went to flash");

   // reset clears every register; looked at while reset is held, so never disabled
   property p_reset_clear;
      disable iff (1'b0)
      reset |-> (ctrl_r == mmd_pkg::REG_RESET) && (ctrl_secondary_r == mmd_pkg::REG_RESET) &&
                (pattern_match_bits_r == mmd_pkg::REG_RESET) &&
                (pattern_exclude_bits_r == mmd_pkg::REG_RESET);
   endproperty
   a_reset_clear: assert property (p_reset_clear) // R3
      else $error("register not cleared while reset is held");

   // in the low window the register block answers at the low base
   property p_reg_low_window;
      (bus.xdata_wr && bus.addr[15:2] == mmd_pkg::REG_BASE_LOW[15:2] &&
       ctrl_r.io_window_high_low_select) |-> reg_write;
   endproperty
   a_reg_low_window: assert property (p_reg_low_window) // R4
      else $error("register write in low window not decoded");

   // relocated i/o area: the first block selects its peripheral, never a ram
   property p_low_window;
      (bus.xdata_rd && ctrl_r.io_window_high_low_select && bus.addr[15:8] == 8'h7D)
         |-> peripheral_select_first && !primary_ram_socket_select &&
             !secondary_ram_socket_select;
   endproperty
   a_low_window: assert property (p_low_window) // R5
      else $error("relocated i/o area not decoded");

   // program model: the upper half is ram on the primary socket, never flash
   property p_prog_map;
      (ctrl_r.flash_program_model_select && xdata_any && bus.addr[15] && !io_hit &&
       primary_ram_socket_present) |-> primary_ram_socket_select && !flash_select;
   endproperty
   a_prog_map: assert property (p_prog_map) // R11
      else $error("program model upper half not mapped to ram");

   // bank lines show what was last written to the primary control register
   property p_bank_lines;
      (reg_write && bus.addr[1:0] == mmd_pkg::OFS_CTRL_PRIMARY) |=>
         flash_upper_addr[3:1] == $past(bus.wdata[mmd_pkg::CTL_BANK_MSB:mmd_pkg::CTL_BANK_LSB]);
   endproperty
   a_bank_lines: assert property (p_bank_lines) // R14
      else $error("flash bank lines do not follow the written bank bits");

   // separate region with sharing on: code fetch goes to flash, not ram
   property p_separate;
      (ctrl_r.shared_code_data_enable && !ctrl_r.flash_program_model_select &&
       bus.code_rd && cmp_diff == 6'h00) |-> flash_read && !ram_read;
   endproperty
   a_separate: assert property (p_separate) // R18 R21
      else $error("separate region code fetch left flash");

   // program model: the shared enable has no effect on low code fetches
   property p_prog_ignores_shared;
      (ctrl_r.flash_program_model_select && ctrl_r.shared_code_data_enable &&
       bus.code_rd && !bus.addr[15]) |-> flash_read && !ram_read;
   endproperty
   a_prog_ignores_shared: assert property (p_prog_ignores_shared) // R16
      else $error("program model honoured the shared enable");

   // all of A14..A10 excluded: only A15 decides, so a matching A15 is separate
   property p_exclude;
      (ctrl_r.shared_code_data_enable && !ctrl_r.flash_program_model_select &&
       bus.code_rd && pattern_exclude_bits_r[6:2] == 5'h1F &&
       bus.addr[15] == pattern_match_bits_r[7]) |-> flash_read && !ram_read;
   endproperty
   a_exclude: assert property (p_exclude) // R22
      else $error("excluded pattern bits still took part in the compare");

   c_prog_model: cover property (ctrl_r.flash_program_model_select && flash_write);
   c_low_window: cover property (ctrl_r.io_window_high_low_select &&
                                 peripheral_select_third);
   c_shared_fetch: cover property (ram_code && !ctrl_r.flash_program_model_select);
   c_swapped: cover property (ctrl_r.ram_half_swap && secondary_ram_socket_select);
   c_bank_lines: cover property (!ctrl_r.flash_program_model_select &&
                                 flash_upper_addr[3:1] == 3'h7);

endmodule

// ===== core/mmd_pkg.sv
/*
 * mmd_pkg: constants and carrier types for the memory model address decoder.
 * Assumes an 8-bit controller bus with a 16-bit address, sampled on clk.
 */
package mmd_pkg;

   // register block offsets inside the decoder's own 256-byte block
   localparam logic [1:0] OFS_CTRL_PRIMARY = 2'h0;
   localparam logic [1:0] OFS_CTRL_SECONDARY = 2'h1;
   localparam logic [1:0] OFS_PATTERN = 2'h2;
   localparam logic [1:0] OFS_EXCLUDE = 2'h3;

   // printed register bases for the two window positions
   localparam logic [15:0] REG_BASE_HIGH = 16'hFC00;
   localparam logic [15:0] REG_BASE_LOW = 16'h7C00;

   // i/o area: address bits 14..10 all ones, bit 15 picks the half
   localparam logic [4:0] IO_AREA_TAG = 5'h1F;

   // 256-byte blocks inside the i/o area, selected by address bits 9..8
   localparam logic [1:0] IO_BLK_REGS = 2'h0;
   localparam logic [1:0] IO_BLK_FIRST = 2'h1;
   localparam logic [1:0] IO_BLK_SECOND = 2'h2;
   localparam logic [1:0] IO_BLK_THIRD = 2'h3;

   // primary control field positions
   localparam int CTL_PROGRAM_BIT = 7;
   localparam int CTL_IO_WINDOW_BIT = 6;
   localparam int CTL_RAM_SWAP_BIT = 5;
   localparam int CTL_SHARED_BIT = 4;
   localparam int CTL_BANK_MSB = 3;
   localparam int CTL_BANK_LSB = 1;
   localparam int CTL_HALF_BIT = 0;

   // pattern and exclude registers use bits 7..2, bits 1..0 reserved
   localparam int CMP_MSB = 7;
   localparam int CMP_LSB = 2;
   localparam logic [7:0] CMP_USED_MASK = 8'hFC;
   localparam logic [7:0] SECONDARY_USED_MASK = 8'h03;

   // every register clears to zero, the default memory model
   localparam logic [7:0] REG_RESET = 8'h00;

   // one controller bus cycle as seen by the decoder
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic xdata_rd;
      logic xdata_wr;
      logic code_rd;
   } mmd_bus_t;

   // decoded primary control register
   typedef struct packed {
      logic flash_program_model_select;
      logic io_window_high_low_select;
      logic ram_half_swap;
      logic shared_code_data_enable;
      logic flash_bank_bit_two;
      logic flash_bank_bit_one;
      logic flash_bank_bit_zero;
      logic flash_half_select_override;
   } mmd_ctrl_t;

endpackage

// ===== dv/mmd_host_model.sv
/*
 * mmd_host_model: the controller side of the decoder's bus, one cycle per clock.
 * Assumes clk comes from the bench and that strobes never overlap.
 */
module mmd_host_model (
   input wire logic clk,
   output mmd_pkg::mmd_bus_t bus
);
   timeunit 1ns;
   timeprecision 1ps;
   // registers cannot be read back, so software keeps its own copy
   logic [7:0] shadow_r [4];
   logic [7:0] wdat;

   initial begin
      bus = '0;
   end

   // kind 0 xdata read, 1 xdata write, 2 code fetch, 3 idle
   task automatic cycle(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] data);
      wdat = data;
      // reserved bits go out as zero
      if (kind == 2'h1 && addr[14:8] == 7'h7C && addr[7:2] == 6'h00) begin
         if (addr[1:0] == mmd_pkg::OFS_CTRL_SECONDARY) begin
            wdat = data & mmd_pkg::SECONDARY_USED_MASK;
         end
         if (addr[1]) wdat = data & mmd_pkg::CMP_USED_MASK;
         shadow_r[addr[1:0]] = wdat;
      end
      @(posedge clk);
      bus.addr <= addr;
      // a released data bus shows the inverse, not the last value
      bus.wdata <= (kind == 2'h1) ? wdat : ~bus.wdata;
      bus.xdata_rd <= (kind == 2'h0);
      bus.xdata_wr <= (kind == 2'h1);
      bus.code_rd <= (kind == 2'h2);
   endtask
endmodule

// ===== dv/tb_top.sv
/*
 * tb_top: self-checking bench for the memory model address decoder.
 * Assumes the decoder's selects are combinational and registers update on clk.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset;
   logic prim_on = 1'b1;
   logic sec_on = 1'b1;
   mmd_pkg::mmd_bus_t bus;
   logic [9:0] sel;
   logic [3:0] up;
   logic [1:0] bank;
   int mismatches = 0;
   int total_checks = 0;

   always #5 clk = ~clk;

   mmd_host_model i_host (.clk(clk), .bus(bus));

   // sel packs flash cs/oe/we, ram sockets, ram oe/we, three peripheral selects
   mmd_decoder i_dut (
      .clk(clk), .reset(reset), .bus(bus),
      .primary_ram_socket_present(prim_on), .secondary_ram_socket_present(sec_on),
      .flash_select(sel[9]), .flash_read(sel[8]), .flash_write(sel[7]),
      .flash_upper_addr(up),
      .primary_ram_socket_select(sel[6]), .secondary_ram_socket_select(sel[5]),
      .ram_read(sel[4]), .ram_write(sel[3]), .ram_bank_addr(bank),
      .peripheral_select_first(sel[2]), .peripheral_select_second(sel[1]),
      .peripheral_select_third(sel[0])
   );

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // one bus cycle, selects looked at mid-cycle once settled
   task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d,
                     input logic [9:0] exp);
      i_host.cycle(k, a, d);
      @(negedge clk);
      chk(sel, exp);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end

   // reset is raised at time zero so the asynchronous clear sees a rising edge
   initial begin
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      op(2'h2, 16'h9000, 8'h00, 10'h300);
      chk({6'h0, up}, 10'h001);
      chk({8'h0, bank}, 10'h000);
      op(2'h0, 16'h1234, 8'h00, 10'h050);
      op(2'h1, 16'h9234, 8'h00, 10'h028);
      op(2'h1, 16'hFD05, 8'h00, 10'h004);
      op(2'h0, 16'hFE00, 8'h00, 10'h002);
      op(2'h1, 16'hFF10, 8'h00, 10'h001);
      op(2'h0, 16'hFC10, 8'h00, 10'h000);
      op(2'h1, 16'hFC04, 8'h40, 10'h000);
      op(2'h0, 16'hFD00, 8'h00, 10'h004);
      op(2'h0, 16'h7D00, 8'h00, 10'h050);
      @(posedge clk);
      sec_on <= 1'b0;
      // the shared ram enables still stand, but no socket is selected
      op(2'h0, 16'h9000, 8'h00, 10'h010);
      @(posedge clk);
      sec_on <= 1'b1;
      prim_on <= 1'b0;
      op(2'h1, 16'h1000, 8'h00, 10'h008);
      @(posedge clk);
      prim_on <= 1'b1;
      op(2'h1, 16'hFC00, 8'h20, 10'h000);
      op(2'h0, 16'h1000, 8'h00, 10'h030);
      op(2'h0, 16'h9000, 8'h00, 10'h050);
      op(2'h1, 16'hFC00, 8'h6E, 10'h000);
      op(2'h1, 16'h7D00, 8'h00, 10'h004);
      op(2'h0, 16'hFD00, 8'h00, 10'h050);
      op(2'h2, 16'h0100, 8'h00, 10'h300);
      chk({6'h0, up}, 10'h00E);
      op(2'h2, 16'h8000, 8'h00, 10'h300);
      chk({6'h0, up}, 10'h00F);
      op(2'h1, 16'hFC00, 8'h00, 10'h048);
      op(2'h0, 16'h7E00, 8'h00, 10'h002);
      op(2'h1, 16'h7C00, 8'hC1, 10'h000);
      op(2'h2, 16'h1000, 8'h00, 10'h300);
      chk({9'h0, up[0]}, 10'h001);
      op(2'h1, 16'h1000, 8'h55, 10'h280);
      op(2'h0, 16'h1000, 8'h00, 10'h000);
      op(2'h2, 16'h9000, 8'h00, 10'h050);
      op(2'h1, 16'h9000, 8'hAA, 10'h048);
      op(2'h1, 16'h7D00, 8'h00, 10'h004);
      op(2'h1, 16'h7C00, 8'hD0, 10'h000);
      op(2'h2, 16'h1000, 8'h00, 10'h300);
      chk({9'h0, up[0]}, 10'h000);
      // second reset in mid-run must restore the default model
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      op(2'h0, 16'hFD00, 8'h00, 10'h004);
      op(2'h1, 16'hFC01, 8'hFF, 10'h000);
      op(2'h3, 16'h0000, 8'h00, 10'h000);
      chk({8'h0, bank}, 10'h003);
      op(2'h1, 16'hFC02, 8'h80, 10'h000);
      op(2'h2, 16'h1000, 8'h00, 10'h300);
      op(2'h1, 16'hFC00, 8'h10, 10'h000);
      op(2'h2, 16'h1000, 8'h00, 10'h050);
      op(2'h2, 16'h8000, 8'h00, 10'h300);
      op(2'h2, 16'h8400, 8'h00, 10'h030);
      op(2'h0, 16'h8000, 8'h00, 10'h030);
      op(2'h1, 16'hFC03, 8'h7C, 10'h000);
      op(2'h2, 16'h8400, 8'h00, 10'h300);
      op(2'h2, 16'h0400, 8'h00, 10'h050);
      op(2'h3, 16'h0000, 8'h00, 10'h000);
      end_sim();
   end
endmodule
